// File: shared/omrg_pkg.sv
// package: constants and types for the overlay memory ready generator
package omrg_pkg;

  // ----------------------------------------
  // widths and limits
  // ----------------------------------------
  localparam int unsigned WAIT_W = 4;
  localparam logic [3:0] WAIT_ZERO = 4'h0;
  localparam logic [3:0] WAIT_MAX = 4'hf;
  localparam logic [3:0] WAIT_FORCED_STD = 4'h1;
  localparam logic [3:0] WAIT_ONE = 4'h1;

  // ----------------------------------------
  // clock threshold for forced wait on the standard board, in kHz
  // ----------------------------------------
  localparam int unsigned FAST_CLK_LIMIT_KHZ = 12500;

  // ----------------------------------------
  // processor segment status encoding (two status bits of a memory cycle)
  // ----------------------------------------
  localparam logic [1:0] SEG_ALT = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_CODE = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // ----------------------------------------
  // space selection bit positions
  // ----------------------------------------
  localparam int unsigned SPACE_CODE_BIT = 0;
  localparam int unsigned SPACE_DATA_BIT = 1;
  localparam logic [1:0] SPACE_RESET = 2'h3;

  // ----------------------------------------
  // switch reset values
  // ----------------------------------------
  localparam logic SW_ON = 1'b1;
  localparam logic SW_OFF = 1'b0;

  // ----------------------------------------
  // generator states
  // ----------------------------------------
  typedef enum logic [1:0] {
    OMRG_IDLE,
    OMRG_WAIT,
    OMRG_DONE
  } omrg_state_t;

endpackage

// File: sim/omrg_cpu_model.sv
// partner: processor side running one bus cycle at a time
`timescale 1ns/1ps
module omrg_cpu_model (
  // clock
  input logic        clk,
  // answer from the overlay
  input logic        overlay_select,
  input logic        overlay_ready,
  // bus cycle pins
  output logic       cycle_start,
  output logic       cycle_end,
  output logic [1:0] cycle_status,
  output logic       cycle_is_memory,
  output logic       addr_mapped
);
  initial {cycle_start, cycle_end, cycle_status, cycle_is_memory, addr_mapped} = '0;
  // waits: edges from select to ready, all ones when unanswered
  task automatic run(input logic [1:0] st, input logic mp, input logic mm, output logic [15:0] waits);
    int n;
    waits = 16'hffff;
    n = 0;
    @(posedge clk);
    #1;
    {cycle_status, addr_mapped, cycle_is_memory} = {st, mp, mm};
    cycle_start = 1'b1;
    while (overlay_select !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (overlay_select === 1'b1 && overlay_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (overlay_ready === 1'b1) waits = 16'(n);
    cycle_end = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    {cycle_start, cycle_end} = 2'h0;
    // released pins show the inverse, not a stale copy
    {cycle_status, addr_mapped, cycle_is_memory} = ~{st, mp, mm};
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// File: sim/omrg_top_chk.sv
// checker: ready timing and decode relations at the generator ports
`timescale 1ns/1ps
module omrg_top_chk (
  // clock and reset
  input logic        clk,
  input logic        rst_b,
  // bus cycle and board pins
  input logic        cycle_end,
  input logic [1:0]  cycle_status,
  input logic        cycle_is_memory,
  input logic        addr_mapped,
  input logic        chip_select_wait_bit_low,
  input logic        chip_select_wait_bit_high,
  input logic        ignore_external_ready_bit,
  input logic        fast_board_fitted,
  input logic [15:0] cpu_clock_khz,
  // generator outputs
  input logic        overlay_select,
  input logic        overlay_ready,
  input logic        target_ready_select,
  input logic        internal_ready_switch,
  input logic [1:0]  mapped_space_select,
  input logic [3:0]  overlay_wait_count,
  input logic [3:0]  waits_inserted
);
  logic [3:0] cs;
  logic [3:0] best;
  logic [3:0] n_held;
  logic       hit;
  logic       fast;
  assign cs = {2'h0, chip_select_wait_bit_high, chip_select_wait_bit_low};
  assign best = (overlay_wait_count > cs) ? overlay_wait_count : cs;
  assign fast = !fast_board_fitted && ({16'h0, cpu_clock_khz} > omrg_pkg::FAST_CLK_LIMIT_KHZ);
  assign hit = mapped_space_select[cycle_status != omrg_pkg::SEG_CODE] && addr_mapped && cycle_is_memory;
  // edges spent with select up and ready held off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) n_held <= 4'h0;
    else if (!overlay_select) n_held <= 4'h0;
    else if (!overlay_ready) n_held <= n_held + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ready_count_a: assert property ($rose(overlay_ready) |-> n_held == waits_inserted)
    else $error("ready not after inserted waits");
  ready_sel_a: assert property (overlay_ready |-> overlay_select) else $error("ready without select");
  zero_wait_a: assert property ($rose(overlay_select) && waits_inserted == 4'h0 |-> overlay_ready)
    else $error("zero waits but ready late");
  fast_board_a: assert property (fast_board_fitted [*4] |=> overlay_wait_count == omrg_pkg::WAIT_ZERO)
    else $error("fast board count not zero");
  std_force_a: assert property (fast [*4] |=> overlay_wait_count >= omrg_pkg::WAIT_FORCED_STD)
    else $error("fast clock count below one");
  cs_only_a: assert property ($rose(overlay_select) && !(internal_ready_switch && !ignore_external_ready_bit)
    |-> waits_inserted == cs) else $error("waits not chip-select count");
  max_wait_a: assert property ($rose(overlay_select) && internal_ready_switch && !ignore_external_ready_bit
    |-> waits_inserted == best) else $error("waits not the larger count");
  space_ok_a: assert property ($rose(overlay_select) |-> hit) else $error("answered a foreign cycle");
  release_a: assert property ($rose(cycle_end) |-> ##[1:4] !overlay_select)
    else $error("select held after end");
  ready_route_a: assert property ($rose(overlay_select) |-> target_ready_select == !internal_ready_switch)
    else $error("ready source not the switch");
  idle_route_a: assert property (!overlay_select |-> target_ready_select)
    else $error("target ready not used outside overlay");
endmodule
bind omrg_top omrg_top_chk chk (.*);

// File: sim/tb.sv
// testbench: overlay ready generator driven through its pins
`timescale 1ns/1ps
module tb;
  logic clk, rst_b, cycle_start, cycle_end, cycle_is_memory, addr_mapped, hit;
  logic chip_select_wait_bit_low, chip_select_wait_bit_high, ignore_external_ready_bit;
  logic fast_board_fitted, switch_write, space_write, wait_write, code_space_choice, data_space_choice;
  logic set_internal_ready, set_internal_timebase, set_trace_run, set_peek_poke_trace;
  logic set_download_verify, set_step_exec_only, overlay_select, overlay_ready, target_ready_select;
  logic internal_timebase_switch, internal_ready_switch, trace_run_enable, peek_poke_trace;
  logic download_verify, step_on_execution_only;
  logic [1:0] cycle_status, mapped_space_select;
  logic [3:0] wait_value, overlay_wait_count, waits_inserted;
  logic [15:0] cpu_clock_khz, w;
  int fails;
  int n_checks;
  omrg_top dut (.*);
  omrg_cpu_model cpu (.*);
  always #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic p);
    p = 1'b1;
    @(posedge clk);
    #1;
    p = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic sws(input logic [5:0] v, input logic wr);
    if (wr) begin
      {set_internal_ready, set_internal_timebase, set_trace_run, set_peek_poke_trace,
       set_download_verify, set_step_exec_only} = v;
      pulse(switch_write);
    end
    // idle: target ready stays routed whatever the switch
    chk({9'h0, target_ready_select, internal_ready_switch, internal_timebase_switch, trace_run_enable,
         peek_poke_trace, download_verify, step_on_execution_only}, {9'h0, 1'b1, v});
  endtask
  task automatic wt(input logic [3:0] v);
    wait_value = v;
    pulse(wait_write);
  endtask
  task automatic cyc(input logic [1:0] s, input logic m, input logic mm, input logic [15:0] e);
    cpu.run(s, m, mm, w);
    chk(w, e);
  endtask
  task automatic mix(input logic [3:0] o, input logic [1:0] c, input logic i, input logic [15:0] e);
    wt(o);
    {chip_select_wait_bit_high, chip_select_wait_bit_low, ignore_external_ready_bit} = {c, i};
    cyc(omrg_pkg::SEG_DATA, 1'b1, 1'b1, e);
  endtask
  task automatic ovc(input logic fb, input logic [15:0] k, input logic [3:0] e);
    {fast_board_fitted, cpu_clock_khz} = {fb, k};
    repeat (6) @(posedge clk);
    #1;
    chk({12'h0, overlay_wait_count}, {12'h0, e});
    cyc(omrg_pkg::SEG_CODE, 1'b1, 1'b1, {12'h0, e});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {clk, rst_b, fails, n_checks} = '0;
    {chip_select_wait_bit_low, chip_select_wait_bit_high, ignore_external_ready_bit, fast_board_fitted} = '0;
    {switch_write, space_write, wait_write, code_space_choice, data_space_choice, wait_value} = '0;
    {set_internal_ready, set_internal_timebase, set_trace_run, set_peek_poke_trace} = '0;
    {set_download_verify, set_step_exec_only, cpu_clock_khz} = {2'h0, 16'h2710};
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    sws(6'h0b, 1'b0);
    chk({14'h0, mapped_space_select}, 16'h3);
    pulse(wait_write);
    chk({12'h0, overlay_wait_count}, 16'h0);
    $display("test defaults done");
    sws(6'h34, 1'b1);
    sws(6'h2b, 1'b1);
    for (int i = 0; i < 16; i++) begin
      wt(4'(i));
      cyc(omrg_pkg::SEG_CODE, 1'b1, 1'b1, 16'(i));
    end
    $display("test speed done");
    mix(4'h1, 2'h3, 1'b0, 16'h3);
    mix(4'h4, 2'h2, 1'b0, 16'h4);
    mix(4'h9, 2'h2, 1'b1, 16'h2);
    sws(6'h0b, 1'b1);
    mix(4'h9, 2'h1, 1'b0, 16'h1);
    mix(4'h0, 2'h0, 1'b0, 16'h0);
    sws(6'h2b, 1'b1);
    $display("test combine done");
    ovc(1'b0, 16'h3e80, 4'h1);
    ovc(1'b0, 16'h30d4, 4'h0);
    wt(4'h7);
    ovc(1'b1, 16'h3e80, 4'h0);
    ovc(1'b0, 16'h3e80, 4'h7);
    wt(4'h0);
    ovc(1'b0, 16'h2710, 4'h0);
    $display("test board done");
    for (int v = 1; v < 4; v++) begin
      {data_space_choice, code_space_choice} = 2'(v);
      pulse(space_write);
      chk({14'h0, mapped_space_select}, 16'(v));
      for (int s = 0; s < 4; s++) begin
        hit = (2'(s) == omrg_pkg::SEG_CODE) ? v[0] : v[1];
        cyc(2'(s), 1'b1, 1'b1, hit ? 16'h0 : 16'hffff);
      end
    end
    cyc(omrg_pkg::SEG_CODE, 1'b0, 1'b1, 16'hffff);
    cyc(omrg_pkg::SEG_CODE, 1'b1, 1'b0, 16'hffff);
    $display("test spaces done");
    summarize();
  end
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule

// File: src/omrg_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module omrg_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// File: src/omrg_top.sv
// overlay memory access qualifier and ready wait-state generator
`timescale 1ns/1ps

module omrg_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // processor bus cycle, from pins
  input  wire logic       cycle_start,
  input  wire logic       cycle_end,
  input  wire logic [1:0] cycle_status,
  input  wire logic       cycle_is_memory,
  input  wire logic       addr_mapped,
  // chip-select wait programming of the cycle
  input  wire logic       chip_select_wait_bit_low,
  input  wire logic       chip_select_wait_bit_high,
  input  wire logic       ignore_external_ready_bit,
  // board and clock facts
  input  wire logic       fast_board_fitted,
  input  wire logic [15:0] cpu_clock_khz,
  // switch writes
  input  wire logic       switch_write,
  input  wire logic       set_internal_ready,
  input  wire logic       set_internal_timebase,
  input  wire logic       set_trace_run,
  input  wire logic       set_peek_poke_trace,
  input  wire logic       set_download_verify,
  input  wire logic       set_step_exec_only,
  input  wire logic       space_write,
  input  wire logic       code_space_choice,
  input  wire logic       data_space_choice,
  input  wire logic       wait_write,
  input  wire logic [3:0] wait_value,
  // outputs to the bus and emulator
  output logic            overlay_select,
  output logic            overlay_ready,
  output logic            target_ready_select,
  output logic            internal_timebase_switch,
  output logic            internal_ready_switch,
  output logic            trace_run_enable,
  output logic            peek_poke_trace,
  output logic            download_verify,
  output logic            step_on_execution_only,
  output logic [1:0]      mapped_space_select,
  output logic [3:0]      overlay_wait_count,
  output logic [3:0]      waits_inserted
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int unsigned SYNC_W = 10;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;

  assign pins_raw = {cycle_start, cycle_end, cycle_status, cycle_is_memory, addr_mapped,
                     chip_select_wait_bit_low, chip_select_wait_bit_high,
                     ignore_external_ready_bit, fast_board_fitted};

  omrg_sync #(.W(SYNC_W)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pins_raw),
    .q     (pins_s)
  );

  logic       s_start;
  logic       s_end;
  logic [1:0] s_status;
  logic       s_mem;
  logic       s_mapped;
  logic [1:0] s_cs_wait;
  logic       s_ign_rdy;
  logic       s_fast;
  logic       s_start_d;

  assign s_start   = pins_s[9];
  assign s_end     = pins_s[8];
  assign s_status  = pins_s[7:6];
  assign s_mem     = pins_s[5];
  assign s_mapped  = pins_s[4];
  assign s_cs_wait = {pins_s[2], pins_s[3]};
  assign s_ign_rdy = pins_s[1];
  assign s_fast    = pins_s[0];

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [3:0] max_wait(input logic [3:0] a, input logic [3:0] b);
    max_wait = (a > b) ? a : b;
  endfunction

  function automatic logic space_hit(input logic [1:0] sel, input logic [1:0] st);
    logic is_code;
    is_code = (st == omrg_pkg::SEG_CODE);
    space_hit = (is_code && sel[omrg_pkg::SPACE_CODE_BIT]) ||
                (!is_code && sel[omrg_pkg::SPACE_DATA_BIT]);
  endfunction

  // ----------------------------------------
  // switches
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trace_run_enable         <= omrg_pkg::SW_ON;
      download_verify          <= omrg_pkg::SW_ON;
      step_on_execution_only   <= omrg_pkg::SW_ON;
      internal_ready_switch    <= omrg_pkg::SW_OFF;
      internal_timebase_switch <= omrg_pkg::SW_OFF;
      peek_poke_trace          <= omrg_pkg::SW_OFF;
    end else if (switch_write) begin
      internal_ready_switch    <= set_internal_ready;
      internal_timebase_switch <= set_internal_timebase;
      trace_run_enable         <= set_trace_run;
      peek_poke_trace          <= set_peek_poke_trace;
      download_verify          <= set_download_verify;
      step_on_execution_only   <= set_step_exec_only;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mapped_space_select <= omrg_pkg::SPACE_RESET;
    end else if (space_write) begin
      mapped_space_select <= {data_space_choice, code_space_choice};
    end
  end

  // ----------------------------------------
  // overlay speed with board forcing
  // ----------------------------------------
  logic       fast_clock;
  logic [3:0] user_wait;
  logic [3:0] next_overlay_wait_count;

  assign fast_clock = (32'(cpu_clock_khz) > omrg_pkg::FAST_CLK_LIMIT_KHZ);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      user_wait <= omrg_pkg::WAIT_ZERO;
    end else if (wait_write) begin
      user_wait <= wait_value;
    end
  end

  always_comb begin
    if (s_fast) begin
      next_overlay_wait_count = omrg_pkg::WAIT_ZERO;
    end else if (fast_clock) begin
      next_overlay_wait_count = max_wait(user_wait, omrg_pkg::WAIT_FORCED_STD);
    end else begin
      next_overlay_wait_count = user_wait;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overlay_wait_count <= omrg_pkg::WAIT_ZERO;
    end else begin
      overlay_wait_count <= next_overlay_wait_count;
    end
  end

  // ----------------------------------------
  // cycle decode and effective wait count
  // ----------------------------------------
  logic       start_pulse;
  logic       hit;
  logic       use_internal;
  logic [3:0] eff_wait;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_start_d <= 1'b0;
    end else begin
      s_start_d <= s_start;
    end
  end

  assign start_pulse  = s_start && !s_start_d;
  assign hit          = s_mem && s_mapped && space_hit(mapped_space_select, s_status);
  assign use_internal = internal_ready_switch && !s_ign_rdy;

  always_comb begin
    if (use_internal) begin
      eff_wait = max_wait(overlay_wait_count, {2'h0, s_cs_wait});
    end else begin
      eff_wait = {2'h0, s_cs_wait};
    end
  end

  // ----------------------------------------
  // wait-state generator
  // ----------------------------------------
  omrg_pkg::omrg_state_t state;
  logic [3:0]            count;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state          <= omrg_pkg::OMRG_IDLE;
      count          <= omrg_pkg::WAIT_ZERO;
      overlay_select <= 1'b0;
      overlay_ready  <= 1'b0;
      waits_inserted <= omrg_pkg::WAIT_ZERO;
      target_ready_select <= 1'b1;
    end else begin
      case (state)
        omrg_pkg::OMRG_IDLE: begin
          overlay_ready <= 1'b0;
          if (start_pulse && hit) begin
            overlay_select      <= 1'b1;
            target_ready_select <= !internal_ready_switch;
            waits_inserted      <= eff_wait;
            count               <= eff_wait;
            if (eff_wait == omrg_pkg::WAIT_ZERO) begin
              overlay_ready <= 1'b1;
              state         <= omrg_pkg::OMRG_DONE;
            end else begin
              state <= omrg_pkg::OMRG_WAIT;
            end
          end
        end
        omrg_pkg::OMRG_WAIT: begin
          count <= count - omrg_pkg::WAIT_ONE;
          if (count == omrg_pkg::WAIT_ONE) begin
            overlay_ready <= 1'b1;
            state         <= omrg_pkg::OMRG_DONE;
          end
          if (s_end) begin
            state          <= omrg_pkg::OMRG_IDLE;
            overlay_select <= 1'b0;
            overlay_ready  <= 1'b0;
            target_ready_select <= 1'b1;
          end
        end
        omrg_pkg::OMRG_DONE: begin
          if (s_end) begin
            overlay_ready       <= 1'b0;
            overlay_select      <= 1'b0;
            target_ready_select <= 1'b1;
            state               <= omrg_pkg::OMRG_IDLE;
          end
        end
        default: begin
          state <= omrg_pkg::OMRG_IDLE;
        end
      endcase
    end
  end

endmodule
